/* File: design/iprep_defs.vh */
`ifndef IPREP_DEFS_VH
`define IPREP_DEFS_VH
// instruction word layout
`define IPREP_IW_W        32
`define IPREP_OPC_MSB     31
`define IPREP_OPC_LSB     24
`define IPREP_CLS_MSB     23
`define IPREP_CLS_LSB     22
`define IPREP_DST_MSB     21
`define IPREP_DST_LSB     18
`define IPREP_LEN_MSB     17
`define IPREP_LEN_LSB     10
// execution classes
`define IPREP_CLS_ARITH   2'h0
`define IPREP_CLS_INSTR   2'h1
`define IPREP_CLS_BRANCH  2'h2
`define IPREP_CLS_BXH     2'h3
// timing
`define IPREP_EXEC_MIN    8'h02
`define IPREP_ILEN        32'h4
`define IPREP_IC_RESET    32'h0
`endif

/* File: design/iprep_buf.v */
`include "iprep_defs.vh"
module iprep_buf #(
  parameter W     = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire          ref_clk,
  input  wire          sys_rst,
  input  wire          clr,
  input  wire          wr_en,
  input  wire [W-1:0]  wr_data,
  input  wire          rd_en,
  output reg  [W-1:0]  rd_data,
  output wire [AW:0]   level
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  assign level = cnt_r;
  always @(posedge ref_clk) begin
    if (wr_en)
      mem[wp_r] <= wr_data;
  end
  // read data registered; shows the next head entry on the same edge the pointer moves
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r    <= {AW{1'b0}};
      rp_r    <= {AW{1'b0}};
      cnt_r   <= {(AW+1){1'b0}};
      rd_data <= {W{1'b0}};
    end else if (clr) begin
      // redirect: buffered words belong to the old path
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (wr_en)
        wp_r <= wp_r + 1'b1;
      if (rd_en)
        rp_r <= rp_r + 1'b1;
      cnt_r   <= cnt_r + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
      rd_data <= mem[rd_en ? rp_r + 1'b1 : rp_r];
    end
  end
endmodule // iprep_buf

/* File: design/iprep_exec_seq.v */
`include "iprep_defs.vh"
module iprep_exec_seq #(
  parameter LW = 8
) (
  input  wire          ref_clk,
  input  wire          sys_rst,
  input  wire          start,
  input  wire [LW-1:0] cycles,
  output wire          first_step,
  output wire          last_step,
  output wire          busy
);
  reg          run_r;
  reg [LW-1:0] left_r;
  assign busy       = run_r;
  assign first_step = start;
  assign last_step  = run_r && (left_r == {{(LW-1){1'b0}}, 1'b1});
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r  <= 1'b0;
      left_r <= {LW{1'b0}};
    end else if (start && !run_r) begin
      // first cycle happens on the start edge; remaining counted here
      run_r  <= 1'b1;
      left_r <= cycles - 1'b1;
    end else if (last_step) begin
      run_r  <= 1'b0;
      left_r <= {LW{1'b0}};
    end else if (run_r) begin
      left_r <= left_r - 1'b1;
    end
  end
endmodule // iprep_exec_seq

/* File: design/iprep_core.v */
`include "iprep_defs.vh"
module iprep_core #(
  parameter IW     = 32,
  parameter DW     = 32,
  parameter AW     = 32,
  parameter DEPTH  = 4,
  parameter DAW    = 2,
  parameter LW     = 8,
  parameter PF_LVL = 2
) (
  input  wire          ref_clk,
  input  wire          sys_rst,
  output reg           fetch_req,
  output reg  [AW-1:0] fetch_addr,
  input  wire          fetch_accept,
  input  wire          fetch_valid,
  input  wire [IW-1:0] fetch_data,
  input  wire [DW-1:0] opnd_a_in,
  input  wire [DW-1:0] opnd_b_in,
  input  wire          branch_target_valid,
  input  wire [AW-1:0] branch_target,
  output reg  [7:0]    exec_opcode_register,
  output reg  [DW-1:0] opnd_a_r,
  output reg  [DW-1:0] opnd_b_r,
  output reg  [AW-1:0] instr_counter_r,
  output reg           prep_step_one,
  output reg           prep_step_two,
  output wire          arith_start,
  output wire          instr_related_start,
  output wire          branch_start,
  output wire [2:0]    unit_busy,
  output wire          exec_first_step,
  output wire          exec_last_cycle_step,
  output reg  [DW-1:0] result_out_r,
  output reg  [3:0]    result_dst_r,
  output reg           result_valid_r,
  output reg           branch_taken_r
);
  // instruction buffer
  wire          buf_rd;
  wire [IW-1:0] buf_head;
  wire [DAW:0]  buf_lvl;
  reg  [DAW:0]  pend_r;
  reg  [DAW:0]  drop_r;
  reg           stale_req_r;
  reg  [IW-1:0] prep_iw_r;
  reg  [DW-1:0] opnd_a_s;
  reg  [DW-1:0] opnd_b_s;
  wire          flush = branch_taken_r;
  // words already requested before a redirect are discarded on return
  wire          buf_wr = fetch_valid && !flush && (drop_r == {(DAW+1){1'b0}});
  wire [DAW:0]  pend_nxt = pend_r + {{DAW{1'b0}}, fetch_req && fetch_accept}
                           - {{DAW{1'b0}}, fetch_valid && (pend_r != 0)};
  iprep_buf #(.W(IW), .DEPTH(DEPTH), .AW(DAW)) u_buf (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clr     (flush),
    .wr_en   (buf_wr),
    .wr_data (fetch_data),
    .rd_en   (buf_rd),
    .rd_data (buf_head),
    .level   (buf_lvl)
  );

  // per-unit sequencers
  reg  [IW-1:0] exec_iw_r;
  reg  [1:0]    exec_cls_r;
  reg  [2:0]    start_r;
  wire [2:0]    first_v;
  wire [2:0]    last_v;
  wire [2:0]    busy_v;
  wire [LW-1:0] len_v = (exec_iw_r[`IPREP_LEN_MSB:`IPREP_LEN_LSB] < `IPREP_EXEC_MIN)
                        ? `IPREP_EXEC_MIN : exec_iw_r[`IPREP_LEN_MSB:`IPREP_LEN_LSB];
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_unit
      iprep_exec_seq #(.LW(LW)) u_seq (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .start      (start_r[g]),
        .cycles     (len_v),
        .first_step (first_v[g]),
        .last_step  (last_v[g]),
        .busy       (busy_v[g])
      );
    end
  endgenerate
  assign arith_start          = start_r[0];
  assign instr_related_start  = start_r[1];
  assign branch_start         = start_r[2];
  assign unit_busy            = busy_v;
  assign exec_first_step      = |first_v;
  // paired units end together on the common last step
  assign exec_last_cycle_step = |last_v;

  // execution in progress: any unit still active or starting
  wire exec_active = (|busy_v) || (|start_r);
  // start allowed when idle or the last step is now ending
  wire exec_free   = !exec_active || (exec_last_cycle_step && !(|start_r));

  // preparation: one shared pair of steps for every class
  // head word latched at step one; the buffer read moves on to the next word
  wire [1:0] head_cls = prep_iw_r[`IPREP_CLS_MSB:`IPREP_CLS_LSB];
  reg        head_ok_r;
  wire       step1_go = !prep_step_one && !prep_step_two && head_ok_r && (buf_lvl != 0)
                        && !flush;
  wire       step2_done = prep_step_two && exec_free;
  assign buf_rd = step1_go;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prep_step_one        <= 1'b0;
      prep_step_two        <= 1'b0;
      start_r              <= 3'h0;
      head_ok_r            <= 1'b0;
      exec_opcode_register <= 8'h00;
      exec_iw_r            <= {IW{1'b0}};
      exec_cls_r           <= 2'h0;
      prep_iw_r            <= {IW{1'b0}};
      opnd_a_s             <= {DW{1'b0}};
      opnd_b_s             <= {DW{1'b0}};
      opnd_a_r             <= {DW{1'b0}};
      opnd_b_r             <= {DW{1'b0}};
      instr_counter_r      <= `IPREP_IC_RESET;
    end else begin
      head_ok_r <= (buf_lvl != 0) && !buf_rd && !flush;
      start_r   <= 3'h0;
      if (flush) begin
        prep_step_one <= 1'b0;
        prep_step_two <= 1'b0;
        head_ok_r     <= 1'b0;
        instr_counter_r <= branch_target;
      end else begin
        prep_step_one <= step1_go;
        if (step1_go)
          prep_iw_r <= buf_head;
        if (prep_step_one) begin
          prep_step_two   <= 1'b1;
          // staged so the running execution keeps its own operands
          opnd_a_s        <= opnd_a_in;
          opnd_b_s        <= opnd_b_in;
          instr_counter_r <= instr_counter_r + `IPREP_ILEN;
        end else if (step2_done) begin
          prep_step_two <= 1'b0;
        end
        if (step2_done) begin
          // opcode lands on the same edge as start, valid during the first step
          exec_opcode_register <= prep_iw_r[`IPREP_OPC_MSB:`IPREP_OPC_LSB];
          exec_iw_r            <= prep_iw_r;
          opnd_a_r             <= opnd_a_s;
          opnd_b_r             <= opnd_b_s;
          exec_cls_r           <= head_cls;
          case (head_cls)
            `IPREP_CLS_ARITH:  start_r <= 3'h1;
            `IPREP_CLS_INSTR:  start_r <= 3'h2;
            `IPREP_CLS_BRANCH: start_r <= 3'h4;
            default:           start_r <= 3'h5;
          endcase
        end
      end
    end
  end

  // head entry leaves the buffer at step one; buffer read marks consumption
  // instruction fetch control with prefetch and conflict suppression
  wire [DAW:0] room = DEPTH[DAW:0] - buf_lvl - pend_r;
  wire         want = (buf_lvl + pend_r) <= PF_LVL[DAW:0] && (room != 0);
  wire         conflict = flush || (branch_start && !fetch_req);
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_req  <= 1'b0;
      fetch_addr <= {AW{1'b0}};
      pend_r     <= {(DAW+1){1'b0}};
      drop_r     <= {(DAW+1){1'b0}};
      stale_req_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      if (flush)
        drop_r <= pend_nxt;
      else
        drop_r <= drop_r + {{DAW{1'b0}}, fetch_req && fetch_accept && stale_req_r}
                         - {{DAW{1'b0}}, fetch_valid && (drop_r != 0)};
      if (fetch_req && fetch_accept)
        stale_req_r <= 1'b0;
      else if (flush && fetch_req)
        stale_req_r <= 1'b1;
      if (fetch_req) begin
        if (fetch_accept) begin
          fetch_req  <= 1'b0;
          fetch_addr <= (flush || stale_req_r) ? branch_target
                                               : fetch_addr + `IPREP_ILEN;
        end
      end else if (flush) begin
        fetch_addr <= branch_target;
      end else if (want && !conflict) begin
        fetch_req <= 1'b1;
      end
    end
  end

  // per-class execution datapath; class selects the working step set
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_out_r   <= {DW{1'b0}};
      result_dst_r   <= 4'h0;
      result_valid_r <= 1'b0;
      branch_taken_r <= 1'b0;
    end else begin
      result_valid_r <= 1'b0;
      branch_taken_r <= 1'b0;
      if (last_v[0] || last_v[1]) begin
        case (exec_cls_r)
          `IPREP_CLS_ARITH: result_out_r <= opnd_a_r + opnd_b_r;
          `IPREP_CLS_INSTR: result_out_r <= opnd_b_r;
          default:          result_out_r <= opnd_a_r - opnd_b_r;
        endcase
        result_dst_r   <= exec_iw_r[`IPREP_DST_MSB:`IPREP_DST_LSB];
        result_valid_r <= 1'b1;
      end
      if (last_v[2] && branch_target_valid) begin
        if (exec_cls_r != `IPREP_CLS_BXH || $signed(opnd_a_r) > $signed(opnd_b_r))
          branch_taken_r <= 1'b1;
      end
    end
  end
endmodule // iprep_core

/* File: testbench/iprep_core_assertions.sv */
module iprep_core_assertions (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        fetch_req,
  input wire [31:0] fetch_addr,
  input wire        fetch_accept,
  input wire        prep_step_one,
  input wire        prep_step_two,
  input wire        arith_start,
  input wire        instr_related_start,
  input wire        branch_start,
  input wire [2:0]  unit_busy,
  input wire        exec_first_step,
  input wire        exec_last_cycle_step,
  input wire        result_valid_r,
  input wire        branch_taken_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  logic run_r;
  wire  go = arith_start | instr_related_start | branch_start;
  // high from a first step until its last step
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      run_r <= 1'b0;
    else if (exec_first_step)
      run_r <= 1'b1;
    else if (exec_last_cycle_step)
      run_r <= 1'b0;
  end
  a_one_exec: assert property (go |-> !run_r)
    else $error("start while an execution runs");
  a_first_is_start: assert property (exec_first_step == go)
    else $error("first step differs from start");
  a_start_after_two: assert property (go |-> $past(prep_step_two))
    else $error("start not after step two");
  a_step_order: assert property ($rose(prep_step_two) |-> $past(prep_step_one))
    else $error("step two without step one");
  a_fetch_hold: assert property (fetch_req && !fetch_accept |=>
    fetch_req && $stable(fetch_addr)) else $error("fetch request dropped early");
  a_result_after: assert property (exec_last_cycle_step && (unit_busy[0] || unit_busy[1]) |=>
    result_valid_r)
    else $error("no result after last step");
  a_reset_idle: assert property ($fell(sys_rst) |->
    !prep_step_one && !prep_step_two && unit_busy == 3'h0) else $error("busy after reset");
  a_min_two: assert property (exec_first_step |-> !exec_last_cycle_step)
    else $error("execution shorter than two");
  a_no_pair: assert property (!(unit_busy[1] && unit_busy[2]))
    else $error("illegal unit pair");
  c_pair: cover property (arith_start && branch_start);
  c_taken: cover property (branch_taken_r);
  c_fetch: cover property (fetch_req && fetch_accept);
endmodule // iprep_core_assertions

/* File: testbench/iprep_fetch_model.sv */
module iprep_fetch_model (
  input  wire         ref_clk,
  input  wire         sys_rst,
  input  wire         slow,
  input  wire         fetch_req,
  input  wire  [31:0] fetch_addr,
  output logic        fetch_accept,
  output logic        fetch_valid,
  output logic [31:0] fetch_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];
  int          wa;
  int          wr;
  // program image: every class, one long execution per 32 words
  function automatic logic [31:0] word_at(logic [31:0] a);
    logic [1:0] c;
    c = a[4:2] == 3'h7 ? 2'h2 : a[4:2] == 3'h3 ? 2'h3 : {1'b0, a[2]};
    return {a[9:2] ^ 8'h5a, c, a[5:2], a[6:2] == 5'h09 ? 8'h0c : 8'h02, 10'h000};
  endfunction
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_accept <= 1'b0;
      fetch_valid <= 1'b0;
      fetch_data <= 32'h0;
      q.delete();
      wa = 0;
      wr = 0;
    end else begin
      fetch_accept <= 1'b0;
      if (fetch_accept)
        q.push_back(fetch_addr);
      if (fetch_req && !fetch_accept) begin
        if (wa == 0) begin
          fetch_accept <= 1'b1;
          wa = slow ? $urandom % 4 : 0;
        end else
          wa--;
      end
      fetch_valid <= 1'b0;
      fetch_data <= ~fetch_data;
      if (q.size() > 0) begin
        if (wr == 0) begin
          fetch_valid <= 1'b1;
          fetch_data <= word_at(q.pop_front());
          wr = slow ? $urandom % 3 : 0;
        end else
          wr--;
      end
    end
  end
endmodule // iprep_fetch_model

/* File: testbench/testbench.sv */
bind iprep_core iprep_core_assertions chk_i (.*);
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        slow = 1'b0;
  logic        branch_target_valid = 1'b0;
  logic [31:0] branch_target = 32'h0;
  logic [31:0] opnd_a_in = 32'h0;
  logic [31:0] opnd_b_in = 32'h0;
  logic [31:0] fetch_addr, fetch_data, opnd_a_r, opnd_b_r, instr_counter_r, result_out_r;
  logic [31:0] w, ea, a1, a2, b1, b2;
  logic        fetch_req, fetch_accept, fetch_valid, prep_step_one, prep_step_two, r1;
  logic        arith_start, instr_related_start, branch_start, exec_first_step;
  logic        exec_last_cycle_step, result_valid_r, branch_taken_r;
  logic [7:0]  exec_opcode_register;
  logic [3:0]  result_dst_r, dst;
  logic [2:0]  unit_busy;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n_ex = 0;
  int          cnt, len, k, n0;
  iprep_core dut (.*);
  iprep_fetch_model fetch_srv (.*);
  always #2 ref_clk = ~ref_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(negedge ref_clk) begin
    opnd_a_in <= $urandom;
    opnd_b_in <= $urandom;
    branch_target_valid <= $urandom % 2;
  end
  // reference model of issue order, operands, lengths
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ea = 32'h0;
      if (r1) chk("idle", 5'h0, {prep_step_one, prep_step_two, unit_busy});
      r1 = 1'b1;
    end else begin
      r1 = 1'b0;
      if (result_valid_r) chk("dest", dst, result_dst_r);
      if (exec_first_step) begin
        w = fetch_srv.word_at(ea);
        chk("opcode", w[31:24], exec_opcode_register);
        chk("units", {w[23] == w[22], !w[23] && w[22], w[23]},
            {arith_start, instr_related_start, branch_start});
        chk("opnd_a", a2, opnd_a_r);
        chk("opnd_b", b2, opnd_b_r);
        dst = w[21:18];
        len = w[17:10];
        cnt = 0;
        ea += 32'h4;
        n_ex++;
      end
      cnt++;
      if (exec_last_cycle_step) chk("length", len, cnt);
      if (branch_taken_r) ea = branch_target;
      if (prep_step_two) begin
        a2 = a1;
        b2 = b1;
      end
      if (prep_step_one) begin
        a1 = opnd_a_in;
        b1 = opnd_b_in;
      end
    end
  end
  initial begin
    void'($urandom(77178));
    for (int t = 0; t < 3; t++) begin
      @(negedge ref_clk);
      sys_rst = 1'b1;
      slow = t[0];
      branch_target = 32'($urandom % 64) << 2;
      repeat (3) @(negedge ref_clk);
      sys_rst = 1'b0;
      n0 = n_ex;
      for (k = 0; k < 4000 && n_ex < n0 + 40; k++)
        @(negedge ref_clk);
      if (n_ex < n0 + 40) begin
        bad_count++;
        $display("unexpected executions: expected 40, seen %0d", n_ex - n0);
        final_report;
      end
      $display("test %0d done, slow %0d", t, slow);
    end
    final_report;
  end
endmodule // testbench
